// ===== core/fscr_pkg.sv
// ----------------------------------------------------------------------------
// filter setup configuration: shared constants and carriers
// ----------------------------------------------------------------------------
package fscr_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0] FSCR_SETUP1_IDX = 8'h29;
    localparam logic [7:0] FSCR_SETUP2_IDX = 8'h2A;
    localparam logic [7:0] FSCR_SETUP1_ADDR = {FSCR_SETUP1_IDX[5:0], 2'b00};
    localparam logic [7:0] FSCR_SETUP2_ADDR = {FSCR_SETUP2_IDX[5:0], 2'b00};

    // register reset value and writable bits of the normal mapping
    localparam logic [15:0] FSCR_CFG_RESET = 16'h0000;
    localparam logic [15:0] FSCR_NORMAL_WR_MASK = 16'h8F7F;

    // field positions
    localparam int unsigned FSCR_MAP_BIT = 15;
    localparam int unsigned FSCR_PF_EN_BIT = 11;
    localparam int unsigned FSCR_PF_SEL_LSB = 8;
    localparam int unsigned FSCR_TYPE_LSB = 5;
    localparam int unsigned FSCR_RATE_LSB = 0;

    // filter type codes
    localparam logic [1:0] FSCR_TYPE_SINC5_SINC1 = 2'h0;
    localparam logic [1:0] FSCR_TYPE_SINC3 = 2'h3;

    // post filter select codes, rates in centi-SPS, settling in microseconds
    localparam logic [2:0] FSCR_PF_27SPS = 3'h2;
    localparam logic [2:0] FSCR_PF_25SPS = 3'h3;
    localparam logic [2:0] FSCR_PF_20SPS = 3'h5;
    localparam logic [2:0] FSCR_PF_16SPS = 3'h6;
    localparam logic [15:0] FSCR_PF27_RATE_CSPS = 16'h0A8C;
    localparam logic [15:0] FSCR_PF25_RATE_CSPS = 16'h09C4;
    localparam logic [15:0] FSCR_PF20_RATE_CSPS = 16'h07D0;
    localparam logic [15:0] FSCR_PF16_RATE_CSPS = 16'h0683;
    localparam logic [15:0] FSCR_PF27_SETTLE_US = 16'h8F5C;
    localparam logic [15:0] FSCR_PF25_SETTLE_US = 16'h9C40;
    localparam logic [15:0] FSCR_PF20_SETTLE_US = 16'hC350;
    localparam logic [15:0] FSCR_PF16_SETTLE_US = 16'hEA60;

    // direct sinc3 mapping: modulator clocks per output = 32 x ratio
    localparam logic [4:0] FSCR_DECIM_SHIFT = 5'h05;

    // rate code limits and the rates in milli-SPS at both ends
    localparam logic [4:0] FSCR_RATE_CODE_MAX = 5'h14;
    localparam logic [27:0] FSCR_RATE_FAST_MSPS = 28'hEE6B280;
    localparam logic [27:0] FSCR_RATE_SLOW_MSPS = 28'h0001388;

    // filter path actually in use
    typedef enum logic [1:0] {
        FSCR_PATH_SINC5_SINC1 = 2'b00,
        FSCR_PATH_SINC3 = 2'b01,
        FSCR_PATH_DIRECT = 2'b11,
        FSCR_PATH_INVALID = 2'b10
    } fscr_path_e;

    // decoded setup handed to the filter datapath
    typedef struct packed {
        fscr_path_e path;
        logic post_active;
        logic [15:0] post_rate_csps;
        logic [15:0] post_settle_us;
        logic [4:0] rate_code;
        logic [27:0] rate_msps;
        logic [19:0] decim_ratio;
    } fscr_setup_s;

endpackage : fscr_pkg

// ===== core/fscr_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - map bit 15 set: low fifteen bits are a direct sinc3 ratio only
// - direct mapping: output rate is modulator clock over 32 times ratio
// - bit 11 enables the post filter, only effective with type code 00
// - post select 010 gives 27 SPS/36.7 ms, 011 gives 25 SPS/40 ms
// - post select 101 gives 20 SPS/50 ms, 110 gives 16.67 SPS/60 ms
// - type bits 6:5: 00 sinc5 plus sinc1 by default, 11 sinc3
// - rate code 00000 is 250000 SPS, stepping down to 5 SPS
// - setup 1 register at index 0x29, setup 2 at 0x2A, reset zero
module fscr_regs
    import fscr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    // decoded setups to the filter datapath, index 0 is setup 1
    output var fscr_setup_s [1:0] setup_cfg
);

    // ------------------------------------------------------------------------
    // rate code table
    // ------------------------------------------------------------------------

    // output data rate in milli-SPS for each code; codes past the slowest read 0
    function automatic logic [27:0] rate_lookup(input logic [4:0] code);
        logic [27:0] r;
        r = 28'h0000000;
        case (code)
            5'h00: r = FSCR_RATE_FAST_MSPS;
            5'h01: r = 28'h7735940;
            5'h02: r = 28'h3B9ACA0;
            5'h03: r = 28'h2FAF080;
            5'h04: r = 28'h1DCD650;
            5'h05: r = 28'h17D7840;
            5'h06: r = 28'h0EE6B28;
            5'h07: r = 28'h0989680;
            5'h08: r = 28'h04C4B40;
            5'h09: r = 28'h02625A0;
            5'h0A: r = 28'h00F4240;
            5'h0B: r = 28'h007A120;
            5'h0C: r = 28'h00610BC;
            5'h0D: r = 28'h0030D40;
            5'h0E: r = 28'h00186A0;
            5'h0F: r = 28'h000EA24;
            5'h10: r = 28'h000C328;
            5'h11: r = 28'h0004E20;
            5'h12: r = 28'h000411B;
            5'h13: r = 28'h0002710;
            5'h14: r = FSCR_RATE_SLOW_MSPS;
            default: r = 28'h0000000;
        endcase
        return r;
    endfunction : rate_lookup

    // ------------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------------

    logic [15:0] cfg [2];
    logic [15:0] next_cfg [2];
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic setup_phase;
    logic hit1;
    logic hit2;
    logic wr_done;

    // answer is prepared in the setup cycle, so access completes with no wait
    assign setup_phase = psel && !penable;
    assign hit1 = (paddr == FSCR_SETUP1_ADDR);
    assign hit2 = (paddr == FSCR_SETUP2_ADDR);
    assign wr_done = psel && penable && pready && pwrite;

    // read data, ready and error for the coming access cycle
    always_comb begin
        next_prdata = 32'h00000000;
        next_pready = setup_phase;
        next_pslverr = 1'b0;
        if (setup_phase) begin
            next_pslverr = !(hit1 || hit2);
            if (!pwrite && hit1) begin
                next_prdata = {16'h0000, cfg[0]};
            end else if (!pwrite && hit2) begin
                next_prdata = {16'h0000, cfg[1]};
            end
        end
    end

    // bus answer flops; outputs come straight from these
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------------

    // byte lanes merge first; the map bit of the result picks which bits keep
    // data, so a direct ratio may use bits the normal mapping reserves
    always_comb begin
        logic [15:0] merged;
        merged = 16'h0000;
        for (int i = 0; i < 2; i++) begin
            next_cfg[i] = cfg[i];
            merged[15:8] = pstrb[1] ? pwdata[15:8] : cfg[i][15:8];
            merged[7:0] = pstrb[0] ? pwdata[7:0] : cfg[i][7:0];
            if (wr_done && ((i == 0) ? hit1 : hit2)) begin
                if (merged[FSCR_MAP_BIT]) begin
                    next_cfg[i] = merged;
                end else begin
                    next_cfg[i] = merged & FSCR_NORMAL_WR_MASK;
                end
            end
        end
    end

    // both setups start at the documented reset value
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg[0] <= FSCR_CFG_RESET;
            cfg[1] <= FSCR_CFG_RESET;
        end else begin
            cfg[0] <= next_cfg[0];
            cfg[1] <= next_cfg[1];
        end
    end

    // ------------------------------------------------------------------------
    // setup decode
    // ------------------------------------------------------------------------

    fscr_setup_s next_setup [2];

    // one decode per setup; the datapath sees a registered copy one cycle later
    for (genvar g = 0; g < 2; g++) begin : g_setup
        logic map_on;
        logic [1:0] ftype;
        logic [2:0] pf_sel;
        logic [4:0] rate;

        assign map_on = cfg[g][FSCR_MAP_BIT];
        assign ftype = cfg[g][FSCR_TYPE_LSB +: 2];
        assign pf_sel = cfg[g][FSCR_PF_SEL_LSB +: 3];
        assign rate = cfg[g][FSCR_RATE_LSB +: 5];

        // the direct ratio overrides every other field; undocumented type
        // codes are flagged invalid rather than guessed at
        always_comb begin
            next_setup[g] = '0;
            if (map_on) begin
                next_setup[g].path = FSCR_PATH_DIRECT;
                next_setup[g].decim_ratio = {cfg[g][14:0], 5'h00};
            end else begin
                case (ftype)
                    FSCR_TYPE_SINC5_SINC1: next_setup[g].path = FSCR_PATH_SINC5_SINC1;
                    FSCR_TYPE_SINC3: next_setup[g].path = FSCR_PATH_SINC3;
                    default: next_setup[g].path = FSCR_PATH_INVALID;
                endcase
                next_setup[g].rate_code = rate;
                next_setup[g].rate_msps = rate_lookup(rate);
                // post filter counts only on the sinc5 plus sinc1 path
                if (cfg[g][FSCR_PF_EN_BIT] && ftype == FSCR_TYPE_SINC5_SINC1) begin
                    next_setup[g].post_active = 1'b1;
                    case (pf_sel)
                        FSCR_PF_27SPS: begin
                            next_setup[g].post_rate_csps = FSCR_PF27_RATE_CSPS;
                            next_setup[g].post_settle_us = FSCR_PF27_SETTLE_US;
                        end
                        FSCR_PF_25SPS: begin
                            next_setup[g].post_rate_csps = FSCR_PF25_RATE_CSPS;
                            next_setup[g].post_settle_us = FSCR_PF25_SETTLE_US;
                        end
                        FSCR_PF_20SPS: begin
                            next_setup[g].post_rate_csps = FSCR_PF20_RATE_CSPS;
                            next_setup[g].post_settle_us = FSCR_PF20_SETTLE_US;
                        end
                        FSCR_PF_16SPS: begin
                            next_setup[g].post_rate_csps = FSCR_PF16_RATE_CSPS;
                            next_setup[g].post_settle_us = FSCR_PF16_SETTLE_US;
                        end
                        default: begin
                            // undocumented select: active, but no rate reported
                            next_setup[g].post_rate_csps = 16'h0000;
                            next_setup[g].post_settle_us = 16'h0000;
                        end
                    endcase
                end
            end
        end

        // registered decode for the datapath
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                setup_cfg[g] <= '0;
            end else begin
                setup_cfg[g] <= next_setup[g];
            end
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    // a read of a mapped register: setup then access
    sequence s_read(logic [7:0] addr);
        psel && !penable && !pwrite && paddr == addr ##1 psel && penable;
    endsequence

    // any write completing at a mapped register
    sequence s_write(logic [7:0] addr);
        psel && !penable && pwrite && paddr == addr ##1 psel && penable && pready;
    endsequence

    read_setup1_a: assert property (
        s_read(FSCR_SETUP1_ADDR) |-> pready && !pslverr && prdata == {16'h0000, cfg[0]})
        else $error("setup 1 read returned wrong data");

    read_setup2_a: assert property (
        s_read(FSCR_SETUP2_ADDR) |-> pready && !pslverr && prdata == {16'h0000, cfg[1]})
        else $error("setup 2 read returned wrong data");

    // an unmapped address must answer at once with an error and no data
    unmapped_err_a: assert property (
        psel && !penable && paddr != FSCR_SETUP1_ADDR && paddr != FSCR_SETUP2_ADDR
            |=> pready && pslverr && prdata == 32'h00000000)
        else $error("unmapped access did not answer with an error");

    reserved_zero_a: assert property (
        s_write(FSCR_SETUP2_ADDR) ##1 !cfg[1][FSCR_MAP_BIT]
            |-> cfg[1][14:12] == 3'h0 && !cfg[1][7])
        else $error("reserved bits of setup 2 not zero");

    reserved_bit7_a: assert property (
        s_write(FSCR_SETUP1_ADDR) ##1 !cfg[0][FSCR_MAP_BIT] |-> !cfg[0][7])
        else $error("reserved bit 7 of setup 1 not zero");

    direct_map_a: assert property (
        cfg[0][FSCR_MAP_BIT] |=> setup_cfg[0].path == FSCR_PATH_DIRECT
            && !setup_cfg[0].post_active && setup_cfg[0].rate_code == 5'h00)
        else $error("direct map did not override setup 1 fields");

    decim_ratio_a: assert property (
        cfg[1][FSCR_MAP_BIT]
            |=> setup_cfg[1].decim_ratio == ({5'h00, $past(cfg[1][14:0])} << FSCR_DECIM_SHIFT))
        else $error("setup 2 decimation is not 32 times ratio");

    post_gate_a: assert property (
        setup_cfg[0].post_active |-> $past(cfg[0][FSCR_PF_EN_BIT])
            && !$past(cfg[0][FSCR_MAP_BIT]) && $past(cfg[0][6:5]) == FSCR_TYPE_SINC5_SINC1)
        else $error("post filter active without its enable and type 00");

    post_27sps_a: assert property (
        setup_cfg[0].post_active && $past(cfg[0][10:8]) == FSCR_PF_27SPS
            |-> setup_cfg[0].post_rate_csps == FSCR_PF27_RATE_CSPS
            && setup_cfg[0].post_settle_us == FSCR_PF27_SETTLE_US)
        else $error("post select 010 gave wrong rate or settling");

    post_25sps_a: assert property (
        setup_cfg[0].post_active && $past(cfg[0][10:8]) == FSCR_PF_25SPS
            |-> setup_cfg[0].post_rate_csps == FSCR_PF25_RATE_CSPS
            && setup_cfg[0].post_settle_us == FSCR_PF25_SETTLE_US)
        else $error("post select 011 gave wrong rate or settling");

    post_20sps_a: assert property (
        setup_cfg[0].post_active && $past(cfg[0][10:8]) == FSCR_PF_20SPS
            |-> setup_cfg[0].post_rate_csps == FSCR_PF20_RATE_CSPS
            && setup_cfg[0].post_settle_us == FSCR_PF20_SETTLE_US)
        else $error("post select 101 gave wrong rate or settling");

    post_16sps_a: assert property (
        setup_cfg[1].post_active && $past(cfg[1][10:8]) == FSCR_PF_16SPS
            |-> setup_cfg[1].post_rate_csps == FSCR_PF16_RATE_CSPS
            && setup_cfg[1].post_settle_us == FSCR_PF16_SETTLE_US)
        else $error("post select 110 gave wrong rate or settling");

    filter_type_a: assert property (
        !cfg[0][FSCR_MAP_BIT] && cfg[0][6:5] == FSCR_TYPE_SINC3
            |=> setup_cfg[0].path == FSCR_PATH_SINC3)
        else $error("type code 11 did not select sinc3");

    rate_ends_a: assert property (
        !cfg[0][FSCR_MAP_BIT] && cfg[0][4:0] == FSCR_RATE_CODE_MAX
            |=> setup_cfg[0].rate_msps == FSCR_RATE_SLOW_MSPS)
        else $error("slowest rate code did not give 5 SPS");

    rate_fast_a: assert property (
        !cfg[1][FSCR_MAP_BIT] && cfg[1][4:0] == 5'h00
            |=> setup_cfg[1].rate_msps == FSCR_RATE_FAST_MSPS)
        else $error("rate code 0 did not give 250000 SPS");

endmodule : fscr_regs

`default_nettype wire

// ===== tb/fscr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module fscr_regs_tb_top
    import fscr_pkg::*;
;
    // ------------------------------------------------------------------------
    // stimulus and observation signals
    // ------------------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic arst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fscr_setup_s [1:0] setup_cfg;
    logic [31:0] rd;
    logic er;
    int n_errors = 0;
    int compares = 0;

    // post filter codes with their expected rate and settling, in table order
    localparam logic [2:0] PF_CODE [4] = '{FSCR_PF_27SPS, FSCR_PF_25SPS, FSCR_PF_20SPS,
        FSCR_PF_16SPS};
    localparam logic [15:0] PF_RATE [4] = '{16'h0A8C, 16'h09C4, 16'h07D0, 16'h0683};
    localparam logic [15:0] PF_SETTLE [4] = '{16'h8F5C, 16'h9C40, 16'hC350, 16'hEA60};

    // 10 ns period
    always #5 sys_clk = ~sys_clk;

    fscr_regs fscr_regs_inst (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .setup_cfg(setup_cfg)
    );

    // ------------------------------------------------------------------------
    // helper tasks
    // ------------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer; starts at the next edge so no signal is driven twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        input logic [3:0] st);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            n_errors++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] st);
        apb(1'b1, a, {16'h0000, d}, st);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        check(what, rd, exp);
    endtask : rd_chk

    // decoded outputs land one edge after the write edge
    task automatic settle;
        @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic results;
        if (n_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        repeat (3) @(posedge sys_clk);
        #1;
        check("ready in reset", 32'(pready), 32'h0);
        check("path1 reset", 32'(setup_cfg[0].path), 32'(FSCR_PATH_SINC5_SINC1));
        @(posedge sys_clk);
        arst_n <= 1'b1;
        rd_chk("setup1 reset", FSCR_SETUP1_ADDR, 32'h0000_0000);
        rd_chk("setup2 reset", FSCR_SETUP2_ADDR, 32'h0000_0000);
        // reserved bits read back zero while the map bit stays clear
        // sinc3 on setup 1 with the post filter enable set, so the post filter stays off
        wr(FSCR_SETUP1_ADDR, 16'h7EFF, 4'h3);
        check("mapped err", 32'(er), 32'h0);
        rd_chk("reserved bits", FSCR_SETUP1_ADDR, 32'h0000_0E7F);
        settle();
        check("sinc3 path", 32'(setup_cfg[0].path), 32'(FSCR_PATH_SINC3));
        check("post off sinc3", 32'(setup_cfg[0].post_active), 32'h0);
        check("rate code", 32'(setup_cfg[0].rate_code), 32'h1F);
        // every documented post filter code, alternating fastest and slowest rate
        for (int i = 0; i < 4; i++) begin
            logic [4:0] rc;
            rc = i[0] ? 5'h14 : 5'h00;
            wr(FSCR_SETUP1_ADDR, {4'h0, 1'b1, PF_CODE[i], 1'b0, 2'b00, rc}, 4'h3);
            settle();
            check("post active", 32'(setup_cfg[0].post_active), 32'h1);
            check("post rate", 32'(setup_cfg[0].post_rate_csps), 32'(PF_RATE[i]));
            check("post settle", 32'(setup_cfg[0].post_settle_us), 32'(PF_SETTLE[i]));
            check("odr", 32'(setup_cfg[0].rate_msps),
                i[0] ? 32'h0000_1388 : 32'h0EE6_B280);
            check("path sinc5", 32'(setup_cfg[0].path), 32'(FSCR_PATH_SINC5_SINC1));
        end
        // undocumented type code: path flagged invalid, post filter stays off
        wr(FSCR_SETUP1_ADDR, 16'h0A20, 4'h3);
        settle();
        check("type invalid", 32'(setup_cfg[0].path), 32'(FSCR_PATH_INVALID));
        check("post off type01", 32'(setup_cfg[0].post_active), 32'h0);
        check("invalid odr", 32'(setup_cfg[0].rate_msps), 32'h0EE6_B280);
        wr(FSCR_SETUP1_ADDR, 16'h0200, 4'h3);
        settle();
        check("post disabled", 32'(setup_cfg[0].post_active), 32'h0);
        // setup 2 post filter, reserved bits written high must read back zero
        wr(FSCR_SETUP2_ADDR, 16'h7E80, 4'h3);
        rd_chk("setup2 reserved", FSCR_SETUP2_ADDR, 32'h0000_0E00);
        settle();
        check("post2 active", 32'(setup_cfg[1].post_active), 32'h1);
        check("post2 rate", 32'(setup_cfg[1].post_rate_csps), 32'(PF_RATE[3]));
        check("post2 settle", 32'(setup_cfg[1].post_settle_us), 32'(PF_SETTLE[3]));
        // direct decimation mapping keeps every low bit
        wr(FSCR_SETUP2_ADDR, 16'hFFFF, 4'h3);
        rd_chk("direct read", FSCR_SETUP2_ADDR, 32'h0000_FFFF);
        settle();
        check("direct path", 32'(setup_cfg[1].path), 32'(FSCR_PATH_DIRECT));
        check("direct post", 32'(setup_cfg[1].post_active), 32'h0);
        check("direct ratio", 32'(setup_cfg[1].decim_ratio), 32'(15'h7FFF) * 32);
        // low byte strobe only: high byte keeps the map bit
        wr(FSCR_SETUP2_ADDR, 16'h0000, 4'h1);
        rd_chk("strobe merge", FSCR_SETUP2_ADDR, 32'h0000_FF00);
        settle();
        check("ratio merge", 32'(setup_cfg[1].decim_ratio), 32'(15'h7F00) * 32);
        // the bare index is not a byte address
        wr(8'h29, 16'hFFFF, 4'h3);
        check("unmapped werr", 32'(er), 32'h1);
        rd_chk("unmapped read", 8'h2A, 32'h0000_0000);
        check("unmapped rerr", 32'(er), 32'h1);
        rd_chk("setup1 kept", FSCR_SETUP1_ADDR, 32'h0000_0200);
        // direct mapping on setup 1 hides enable, select, type and rate
        wr(FSCR_SETUP1_ADDR, 16'h8A1F, 4'h3);
        settle();
        check("direct path1", 32'(setup_cfg[0].path), 32'(FSCR_PATH_DIRECT));
        check("direct post1", 32'(setup_cfg[0].post_active), 32'h0);
        check("direct rate1", 32'(setup_cfg[0].rate_code), 32'h0);
        check("direct ratio1", 32'(setup_cfg[0].decim_ratio), 32'h0000_0A1F * 32);
        // a second reset in mid-run clears the registers again
        @(posedge sys_clk);
        arst_n <= 1'b0;
        @(posedge sys_clk);
        arst_n <= 1'b1;
        rd_chk("setup2 rereset", FSCR_SETUP2_ADDR, 32'h0000_0000);
        rd_chk("setup1 rereset", FSCR_SETUP1_ADDR, 32'h0000_0000);
        check("path1 rereset", 32'(setup_cfg[0].path), 32'(FSCR_PATH_SINC5_SINC1));
        check("ratio1 rereset", 32'(setup_cfg[0].decim_ratio), 32'h0);
        results();
    end

    // watchdog, far beyond the hundred or fewer cycles the sequence needs
    initial begin
        #100000;
        n_errors++;
        results();
    end

endmodule : fscr_regs_tb_top

`default_nettype wire
